// ---- rtl/dsl_consts.vh ----
// Constants for the serial load control block
`ifndef DSL_CONSTS_VH
`define DSL_CONSTS_VH
`define DSL_WORD_BITS 24
`define DSL_CNT_W 5
// Counter value while the last bit of a word is taken
`define DSL_LAST_BIT 5'h17
`define DSL_CODE_W 10
`define DSL_ZERO_CODE 10'h000
// Word layout: [23:20] command, [19:16] unused, [15:6] code
`define DSL_CMD_MSB 23
`define DSL_CMD_LSB 20
`define DSL_CODE_MSB 15
`define DSL_CODE_LSB 6
// Control word fields, in the low data bits
`define DSL_CTL_GAIN_BIT 11
`define DSL_CTL_REFOFF_BIT 12
`define DSL_CTL_GAIN_RST 1'h0
`define DSL_CTL_REFOFF_RST 1'h0
// Commands
`define DSL_CMD_WR_IN 4'h1
`define DSL_CMD_UPD 4'h2
`define DSL_CMD_WR_UPD 4'h3
`define DSL_CMD_CTL 4'h4
`endif

// ---- rtl/dsl_sync.v ----
// Two flip-flop synchroniser for a group of pin inputs
module dsl_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Data
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  // Resets to ones, the idle level of the clock and strobe pins
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_q <= {W{1'b1}};
      sync_out <= {W{1'b1}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ---- rtl/dsl_top.v ----
// Four-wire serial load control of a 10-bit converter
`include "dsl_consts.vh"

module dsl_top (
  // Clock and resets
  input wire clk_in,
  input wire sys_rst_in,
  input wire reset_pin_n_in,
  // Serial link
  input wire sclk_in,
  input wire frame_sel_n_in,
  input wire serial_data_in,
  // Load strobe
  input wire load_strobe_n_in,
  // Converter side
  output reg [9:0] conv_code_out,
  output reg [9:0] input_code_out,
  output reg gain_two_out,
  output reg ref_out_en_out,
  output reg pending_out
);
  wire [4:0] pins_s;
  wire rst_any;
  reg rst_pin_meta_q;
  reg rst_pin_q;
  reg sclk_q;
  reg load_strobe_n_q;
  reg frame_q;
  reg [23:0] shift_q;
  reg [4:0] cnt_q;
  reg [23:0] word_d;
  reg [3:0] cmd_d;

  // ==========================================================
  // Pin synchronisation
  dsl_sync #(.W(4)) u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({sclk_in, frame_sel_n_in, load_strobe_n_in,
               serial_data_in}),
    .sync_out(pins_s[3:0])
  );
  assign pins_s[4] = rst_pin_q;

  // ==========================================================
  // Hardware reset pin, held low forces reset
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rst_pin_meta_q <= 1'b0;
      rst_pin_q <= 1'b0;
    end else begin
      rst_pin_meta_q <= reset_pin_n_in;
      rst_pin_q <= rst_pin_meta_q;
    end
  end
  assign rst_any = ~pins_s[4];

  // ==========================================================
  // Edge detection
  wire sclk_fall = sclk_q & ~pins_s[3];
  wire frame_fall = frame_q & ~pins_s[2];
  wire frame_rise = ~frame_q & pins_s[2];
  wire load_strobe_n_fall = load_strobe_n_q & ~pins_s[1];
  wire load_strobe_n_low = ~pins_s[1];

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_q <= 1'b1;
      frame_q <= 1'b1;
      load_strobe_n_q <= 1'b1;
    end else begin
      sclk_q <= pins_s[3];
      frame_q <= pins_s[2];
      load_strobe_n_q <= pins_s[1];
    end
  end

  // ==========================================================
  // Frame tracking, a word counts only once it is full
  localparam RX_IDLE = 3'b001;
  localparam RX_SHIFT = 3'b010;
  localparam RX_FULL = 3'b100;
  reg [2:0] rx_state_q;
  reg [2:0] rx_state_d;
  wire bit_take = rx_state_q == RX_SHIFT && !pins_s[2] && sclk_fall;

  always @* begin
    rx_state_d = rx_state_q;
    case (rx_state_q)
      RX_IDLE: begin
        if (frame_fall) begin
          rx_state_d = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (frame_rise) begin
          rx_state_d = RX_IDLE;
        end else if (bit_take && cnt_q == `DSL_LAST_BIT) begin
          rx_state_d = RX_FULL;
        end
      end
      RX_FULL: begin
        if (frame_rise) begin
          rx_state_d = RX_IDLE;
        end
      end
      default: begin
        rx_state_d = RX_IDLE;
      end
    endcase
  end

  // Frame cut by reset is dropped, a new frame must start
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_state_q <= RX_IDLE;
    end else if (rst_any) begin
      rx_state_q <= RX_IDLE;
    end else begin
      rx_state_q <= rx_state_d;
    end
  end

  // ==========================================================
  // Shift register and bit counter
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shift_q <= 24'h000000;
      cnt_q <= 5'h00;
    end else if (rst_any) begin
      shift_q <= 24'h000000;
      cnt_q <= 5'h00;
    end else if (frame_fall) begin
      cnt_q <= 5'h00;
    end else if (bit_take) begin
      shift_q <= {shift_q[22:0], pins_s[0]};
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // ==========================================================
  // Command decode, shared by the write and update paths
  function cmd_loads_input;
    input [3:0] cmd;
    begin
      cmd_loads_input = cmd == `DSL_CMD_WR_IN || cmd == `DSL_CMD_WR_UPD;
    end
  endfunction

  function cmd_updates_conv;
    input [3:0] cmd;
    begin
      cmd_updates_conv = cmd == `DSL_CMD_UPD || cmd == `DSL_CMD_WR_UPD;
    end
  endfunction

  wire word_ok = frame_rise && rx_state_q == RX_FULL;
  always @* begin
    word_d = shift_q;
    cmd_d = word_d[`DSL_CMD_MSB:`DSL_CMD_LSB];
  end
  wire wr_in = word_ok && cmd_loads_input(cmd_d);
  wire sw_upd = word_ok && cmd_updates_conv(cmd_d);
  wire wr_ctl = word_ok && cmd_d == `DSL_CMD_CTL;
  wire [9:0] new_code = word_d[`DSL_CODE_MSB:`DSL_CODE_LSB];

  // ==========================================================
  // Input, converter and control registers
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      input_code_out <= `DSL_ZERO_CODE;
      conv_code_out <= `DSL_ZERO_CODE;
      pending_out <= 1'b0;
      gain_two_out <= `DSL_CTL_GAIN_RST;
      ref_out_en_out <= ~`DSL_CTL_REFOFF_RST;
    end else if (rst_any) begin
      input_code_out <= `DSL_ZERO_CODE;
      conv_code_out <= `DSL_ZERO_CODE;
      pending_out <= 1'b0;
      gain_two_out <= `DSL_CTL_GAIN_RST;
      ref_out_en_out <= ~`DSL_CTL_REFOFF_RST;
    end else begin
      if (wr_ctl) begin
        gain_two_out <= word_d[`DSL_CTL_GAIN_BIT];
        ref_out_en_out <= ~word_d[`DSL_CTL_REFOFF_BIT];
      end
      if (wr_in) begin
        input_code_out <= new_code;
      end
      if (wr_in && (load_strobe_n_low || sw_upd)) begin
        conv_code_out <= new_code;
        pending_out <= 1'b0;
      end else if (wr_in) begin
        pending_out <= 1'b1;
      end else if ((load_strobe_n_fall || sw_upd) && pending_out) begin
        conv_code_out <= input_code_out;
        pending_out <= 1'b0;
      end
    end
  end
endmodule

// ---- tb/dsl_host_model.sv ----
// Host model driving the clock, frame and data wires of the serial link
module dsl_host_model (
  input logic clk_in,
  output logic sclk_out = 1'b1,
  output logic frame_n_out = 1'b1,
  output logic data_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic send(input logic [23:0] w, input int n);
    frame_n_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      data_out <= w[23-i];
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
    end
    repeat (4) @(posedge clk_in);
    frame_n_out <= 1'b1;
    data_out <= ~data_out;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// ---- tb/dsl_top_sva.sv ----
// Port checker for the serial load control block
module dsl_top_sva (
  input logic clk_in, sys_rst_in, reset_pin_n_in, sclk_in,
  input logic frame_sel_n_in, serial_data_in, load_strobe_n_in,
  input logic [9:0] conv_code_out, input_code_out,
  input logic gain_two_out, ref_out_en_out, pending_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic quiet;
  assign quiet = frame_sel_n_in && reset_pin_n_in;
  chk_pin_reset: assert property (!reset_pin_n_in [*5] |->
    !conv_code_out && !input_code_out && !pending_out) else $error("rst");
  chk_conv_match: assert property ($changed(conv_code_out) |->
    conv_code_out == input_code_out) else $error("conv");
  chk_strobe_load: assert property ($fell(load_strobe_n_in)
    && pending_out |-> ##[1:6] !pending_out) else $error("load");
  chk_pend_done: assert property ($fell(pending_out) |->
    conv_code_out == input_code_out) else $error("pend");
  chk_auto_update: assert property (!load_strobe_n_in [*8]
    ##0 $changed(input_code_out) |-> ##[0:4] !pending_out
    && conv_code_out == input_code_out) else $error("auto");
  chk_frame_quiet: assert property (quiet [*8] |->
    $stable(input_code_out) && $stable(gain_two_out)) else $error("frm");
  chk_strobe_quiet: assert property ((quiet && load_strobe_n_in) [*8]
    |-> $stable(conv_code_out) && $stable(pending_out)) else $error("stb");
  chk_ctl_default: assert property (!reset_pin_n_in [*5]
    ##1 reset_pin_n_in |-> ref_out_en_out && !gain_two_out) else $error("c");
  cover property ($fell(pending_out));
  cover property ($fell(ref_out_en_out));
  cover property (!load_strobe_n_in && $changed(conv_code_out));
endmodule
bind dsl_top dsl_top_sva u_dsl_top_sva (.clk_in, .sys_rst_in,
  .reset_pin_n_in, .sclk_in, .frame_sel_n_in, .serial_data_in,
  .load_strobe_n_in, .conv_code_out, .input_code_out, .gain_two_out,
  .ref_out_en_out, .pending_out);

// ---- tb/dsl_top_test.sv ----
// Self-checking bench for the serial load control block
`include "dsl_consts.vh"
module dsl_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, rst_n = 1'b1, ld_n = 1'b1;
  logic sck, fr_n, sd, gain, refen, pend;
  logic [9:0] conv, inp;
  int failures = 0, n_compared = 0, cycles = 0;
  always #10 clk_in = ~clk_in;
  dsl_top u_dsl_top (.clk_in, .sys_rst_in, .reset_pin_n_in(rst_n),
    .sclk_in(sck), .frame_sel_n_in(fr_n), .serial_data_in(sd),
    .load_strobe_n_in(ld_n), .conv_code_out(conv), .input_code_out(inp),
    .gain_two_out(gain), .ref_out_en_out(refen), .pending_out(pend));
  dsl_host_model u_dsl_host_model (.clk_in, .sclk_out(sck),
    .frame_n_out(fr_n), .data_out(sd));
  function automatic logic [23:0] w(logic [3:0] cm, logic [9:0] cd);
    return {cm, 4'h0, cd, 6'h00};
  endfunction
  task automatic send(input logic [23:0] v, input int n = 24);
    u_dsl_host_model.send(v, n);
  endtask
  task automatic check(input logic [2:0] f, input logic [9:0] c, i);
    @(negedge clk_in);
    n_compared++;
    if ({pend, gain, refen, conv, inp} !== {f, c, i}) begin
      failures++;
      $display("[FAIL] %0t %h %h", $time, {pend, gain, refen, conv, inp},
        {f, c, i});
    end
    @(posedge clk_in);
  endtask
  task automatic pulse;
    ld_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    ld_n <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
  task automatic t_load;
    send(w(`DSL_CMD_WR_IN, 10'h3FF));
    check(3'h5, 10'h000, 10'h3FF);
    pulse();
    check(3'h1, 10'h3FF, 10'h3FF);
    pulse();
    check(3'h1, 10'h3FF, 10'h3FF);
  endtask
  task automatic t_short;
    send(w(`DSL_CMD_WR_UPD, 10'h155), 23);
    check(3'h1, 10'h3FF, 10'h3FF);
    send(w(`DSL_CMD_WR_IN, 10'h0F0));
    check(3'h5, 10'h3FF, 10'h0F0);
    send(w(`DSL_CMD_UPD, 10'h000));
    check(3'h1, 10'h0F0, 10'h0F0);
  endtask
  task automatic t_ctl;
    send({`DSL_CMD_CTL, 20'h01800});
    check(3'h2, 10'h0F0, 10'h0F0);
    send(w(`DSL_CMD_WR_UPD, 10'h001));
    check(3'h2, 10'h001, 10'h001);
  endtask
  task automatic t_auto;
    ld_n <= 1'b0;
    repeat (8) @(posedge clk_in);
    send(w(`DSL_CMD_WR_IN, 10'h2AA));
    check(3'h2, 10'h2AA, 10'h2AA);
    ld_n <= 1'b1;
  endtask
  task automatic t_pin;
    rst_n <= 1'b0;
    send(w(`DSL_CMD_WR_IN, 10'h155));
    check(3'h1, 10'h000, 10'h000);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk_in);
    check(3'h1, 10'h000, 10'h000);
    send(w(`DSL_CMD_WR_IN, 10'h200));
    check(3'h5, 10'h000, 10'h200);
  endtask
  task automatic print_verdict;
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    check(3'h1, 10'h000, 10'h000);
    t_load();
    t_short();
    t_ctl();
    t_auto();
    t_pin();
    print_verdict();
  end
endmodule
